// File: src/duc_top.sv
// dual clock presettable up/down counter, decade or binary variant
`timescale 1ns/1ps
`include "duc_map.svh"
module duc_top
  import duc_pkg::*;
#(
  parameter int WIDTH  = `DUC_CNT_W,
  parameter bit DECADE = 1'b0
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // count clocks from the outside logic
  input  wire logic       up_clock,
  input  wire logic       down_clock,
  // override controls
  input  wire logic       master_reset,
  input  wire logic       parallel_load_n,
  input  wire duc_count_t preset_data,
  // counter outputs
  output duc_count_t      count_value,
  output logic            carry_out_n,
  output logic            borrow_out_n
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (WIDTH != `DUC_CNT_W) begin : g_bad_width
    $error("duc_top only supports a four bit count");
  end

  // ************************************************************
  // declarations
  // ************************************************************
  duc_pins_if pins ();

  duc_count_t count_reg;
  duc_count_t count_next;
  duc_count_t inc_value;
  duc_count_t dec_value;
  duc_count_t max_value;
  duc_mode_t  mode;
  logic       up_prev_reg;
  logic       down_prev_reg;
  logic       up_rise;
  logic       down_rise;
  logic       hold_lsb;
  logic       carry_reg;
  logic       carry_next;
  logic       borrow_reg;
  logic       borrow_next;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  duc_sync u_sync (
    .clk             (clk),
    .rst             (rst),
    .up_clock        (up_clock),
    .down_clock      (down_clock),
    .master_reset    (master_reset),
    .parallel_load_n (parallel_load_n),
    .preset_data     (preset_data),
    .pins            (pins.src)
  );

  // ************************************************************
  // step arithmetic
  // ************************************************************
  duc_step #(
    .DECADE (DECADE)
  ) u_step (
    .value_in (count_reg),
    .inc_out  (inc_value),
    .dec_out  (dec_value)
  );

  assign max_value = duc_max(DECADE);

  // ************************************************************
  // count clock edge detection
  // ************************************************************
  // edge history keeps running through reset and load, so a clock that
  // stays low across them still yields a counted rise afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      up_prev_reg   <= `DUC_CLK_IDLE;
      down_prev_reg <= `DUC_CLK_IDLE;
    end else begin
      up_prev_reg   <= pins.up_lvl; // [RL14]
      down_prev_reg <= pins.down_lvl; // [RL14]
    end
  end

  assign up_rise   = pins.up_lvl & ~up_prev_reg;
  assign down_rise = pins.down_lvl & ~down_prev_reg;

  // ************************************************************
  // mode decode
  // ************************************************************
  // simultaneous rises on both clocks leave the count unchanged
  always_comb begin
    if (pins.master_reset_lvl) begin
      mode = DUC_RESET; // [RL13]
    end else if (!pins.parallel_load_n_lvl) begin
      mode = DUC_LOAD; // [RL12]
    end else if (up_rise && !down_rise) begin
      mode = DUC_UP; // [RL1]
    end else if (down_rise && !up_rise) begin
      mode = DUC_DOWN; // [RL2]
    end else begin
      mode = DUC_HOLD;
    end
  end

  // the other clock low freezes bit 0: counts by two or not at all
  always_comb begin
    case (mode)
      DUC_UP:   hold_lsb = ~pins.down_lvl; // [RL7]
      DUC_DOWN: hold_lsb = ~pins.up_lvl; // [RL7]
      default:  hold_lsb = 1'b0;
    endcase
  end

  // ************************************************************
  // next count
  // ************************************************************
  always_comb begin
    case (mode)
      DUC_RESET: count_next = `DUC_ZERO; // [RL13]
      DUC_LOAD:  count_next = pins.preset_lvl; // [RL12]
      DUC_UP:    count_next = inc_value; // [RL1] [RL4] [RL15]
      DUC_DOWN:  count_next = dec_value; // [RL2] [RL4] [RL15]
      DUC_HOLD:  count_next = count_reg;
      default:   count_next = count_reg;
    endcase
    if (hold_lsb) begin
      count_next[0] = count_reg[0]; // [RL7]
    end
  end

  // all four bits load on one edge, never one after another
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= `DUC_CNT_RST;
    end else begin
      count_reg <= count_next; // [RL3] [RL5]
    end
  end

  // ************************************************************
  // terminal count outputs
  // ************************************************************
  // formed from next count and present clock level so they line up
  // with the count register and the edge history in the same cycle
  assign carry_next  = ~((count_next == max_value) & ~pins.up_lvl); // [RL9] [RL11]
  assign borrow_next = ~((count_next == `DUC_ZERO) & ~pins.down_lvl); // [RL10] [RL11]

  always_ff @(posedge clk) begin
    if (rst) begin
      carry_reg  <= `DUC_TC_IDLE;
      borrow_reg <= `DUC_TC_IDLE;
    end else begin
      carry_reg  <= carry_next; // [RL8]
      borrow_reg <= borrow_next; // [RL8]
    end
  end

  assign count_value  = count_reg;
  assign carry_out_n  = carry_reg;
  assign borrow_out_n = borrow_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_count_up;
    @(posedge clk) disable iff (rst)
      (up_rise && pins.down_lvl && !down_rise && !pins.master_reset_lvl
       && pins.parallel_load_n_lvl)
      |=> (count_reg == (($past(count_reg) == max_value) ? `DUC_ZERO
                         : duc_count_t'($past(count_reg) + `DUC_ONE)));
  endproperty
  a_count_up: assert property (p_count_up) // [RL1]
    else $error("up step did not add one");

  property p_count_down;
    @(posedge clk) disable iff (rst)
      (down_rise && pins.up_lvl && !up_rise && !pins.master_reset_lvl
       && pins.parallel_load_n_lvl)
      |=> (count_reg == (($past(count_reg) == `DUC_ZERO) ? max_value
                         : duc_count_t'($past(count_reg) - `DUC_ONE)));
  endproperty
  a_count_down: assert property (p_count_down) // [RL2]
    else $error("down step did not subtract one");

  property p_decade_range;
    @(posedge clk) disable iff (rst)
      (DECADE && count_reg <= `DUC_DEC_MAX && pins.parallel_load_n_lvl)
      |=> (count_reg <= `DUC_DEC_MAX);
  endproperty
  a_decade_range: assert property (p_decade_range) // [RL4]
    else $error("decade count left 0 to 9");

  property p_no_spurious_change;
    @(posedge clk) disable iff (rst)
      (!$stable(count_reg))
      |-> $past(up_rise || down_rise || pins.master_reset_lvl
                || !pins.parallel_load_n_lvl);
  endproperty
  a_no_spurious_change: assert property (p_no_spurious_change) // [RL5]
    else $error("count changed with no cause");

  property p_lsb_frozen;
    @(posedge clk) disable iff (rst)
      ((up_rise && !pins.down_lvl) || (down_rise && !pins.up_lvl))
      && !pins.master_reset_lvl && pins.parallel_load_n_lvl
      |=> (count_reg[0] == $past(count_reg[0]));
  endproperty
  a_lsb_frozen: assert property (p_lsb_frozen) // [RL7]
    else $error("bit 0 toggled with a count clock low");

  property p_carry;
    @(posedge clk) disable iff (rst)
      carry_out_n == !((count_value == max_value) && !up_prev_reg);
  endproperty
  a_carry: assert property (p_carry) // [RL9]
    else $error("carry out wrong for count and up clock");

  property p_borrow;
    @(posedge clk) disable iff (rst)
      borrow_out_n == !((count_value == `DUC_ZERO) && !down_prev_reg);
  endproperty
  a_borrow: assert property (p_borrow) // [RL10]
    else $error("borrow out wrong for count and down clock");

  property p_carry_rises;
    @(posedge clk) disable iff (rst)
      (!carry_out_n && pins.up_lvl) |=> carry_out_n;
  endproperty
  a_carry_rises: assert property (p_carry_rises) // [RL11]
    else $error("carry did not release with up clock");

  property p_borrow_rises;
    @(posedge clk) disable iff (rst)
      (!borrow_out_n && pins.down_lvl) |=> borrow_out_n;
  endproperty
  a_borrow_rises: assert property (p_borrow_rises) // [RL11]
    else $error("borrow did not release with down clock");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (mode == DUC_HOLD) |=> $stable(count_reg);
  endproperty
  a_hold: assert property (p_hold) // [RL5]
    else $error("count moved without a count event");

  property p_load;
    @(posedge clk) disable iff (rst)
      (!pins.master_reset_lvl && !pins.parallel_load_n_lvl)
      |=> (count_reg == $past(pins.preset_lvl));
  endproperty
  a_load: assert property (p_load) // [RL12]
    else $error("preset data not loaded");

  property p_reset;
    @(posedge clk) disable iff (rst)
      pins.master_reset_lvl |=> (count_reg == `DUC_ZERO) && borrow_out_n == !(!down_prev_reg);
  endproperty
  a_reset: assert property (p_reset) // [RL13]
    else $error("master reset did not clear count");

  property p_idle_high;
    @(posedge clk) disable iff (rst)
      (up_prev_reg && down_prev_reg) |-> (carry_out_n && borrow_out_n);
  endproperty
  a_idle_high: assert property (p_idle_high) // [RL8]
    else $error("terminal count low with clocks high");

  property p_wrap_up;
    @(posedge clk) disable iff (rst)
      (mode == DUC_UP && pins.down_lvl && count_reg == max_value)
      |=> (count_reg == `DUC_ZERO);
  endproperty
  a_wrap_up: assert property (p_wrap_up) // [RL15]
    else $error("up count did not wrap to zero");

  property p_low_through_load;
    @(posedge clk) disable iff (rst)
      (!pins.up_lvl && !pins.parallel_load_n_lvl) ##1
      (!pins.up_lvl && pins.parallel_load_n_lvl && !pins.master_reset_lvl)
      |-> !up_prev_reg;
  endproperty
  a_low_through_load: assert property (p_low_through_load) // [RL14]
    else $error("edge history lost across load");

  // ************************************************************
  // coverage
  // ************************************************************
  c_up_step:   cover property (@(posedge clk) disable iff (rst) mode == DUC_UP);
  c_down_step: cover property (@(posedge clk) disable iff (rst) mode == DUC_DOWN);
  c_load:      cover property (@(posedge clk) disable iff (rst) mode == DUC_LOAD);
  c_carry:     cover property (@(posedge clk) disable iff (rst) $fell(carry_out_n));
  c_borrow:    cover property (@(posedge clk) disable iff (rst) $fell(borrow_out_n));

endmodule // duc_top

// File: pkg/duc_map.svh
// constants for the dual clock up/down counter
//
// Overview of operation
// RL1 - rising up clock with down clock high, no reset or load: count plus one
// RL2 - rising down clock with up clock high, no reset or load: count minus one
// RL3 - decade or 4-bit binary variant; count held in four flip-flops
// RL4 - decade variant counts in 8421 binary-coded decimal
// RL5 - all bits step together from common up and down lines, no ripple
// RL6 - outside logic holds the idle count clock high while counting
// RL7 - lowest bit cannot toggle while either count clock is low
// RL8 - carry and borrow outputs are active low and rest high
// RL9 - carry low while count at maximum and up clock low
// RL10 - borrow low while count is zero and down clock low
// RL11 - carry and borrow repeat clock low phase, usable as next stage clocks
// RL12 - load low with reset low copies preset data into count
// RL13 - reset high forces count to zero, overrides load and clocks
// RL14 - clock low through reset or load: its next rise still counts
// RL15 - counter wraps at limits, decade 9 to 0, binary 15 to 0
`ifndef DUC_MAP_SVH
`define DUC_MAP_SVH

// ************************************************************
// count field
// ************************************************************
`define DUC_CNT_W    4
`define DUC_ZERO     4'h0
`define DUC_ONE      4'h1
`define DUC_DEC_MAX  4'h9
`define DUC_BIN_MAX  4'hF
`define DUC_CNT_RST  4'h0
`define DUC_TC_IDLE  1'b1

// ************************************************************
// synchronised pin vector layout
// ************************************************************
`define DUC_SYNC_W   8
`define DUC_PIN_UP   0
`define DUC_PIN_DN   1
`define DUC_PIN_MR   2
`define DUC_PIN_LDN  3
`define DUC_PIN_PRE  4
`define DUC_SYNC_RST 8'h0B
`define DUC_CLK_IDLE 1'b1

`endif

// File: pkg/duc_pkg.sv
// types and shared helpers for the dual clock up/down counter
`include "duc_map.svh"
package duc_pkg;

  typedef logic [`DUC_CNT_W-1:0] duc_count_t;

  typedef enum logic [2:0] {
    DUC_HOLD,
    DUC_RESET,
    DUC_LOAD,
    DUC_UP,
    DUC_DOWN
  } duc_mode_t;

  function automatic duc_count_t duc_max(input logic decade);
    duc_max = decade ? `DUC_DEC_MAX : `DUC_BIN_MAX;
  endfunction

endpackage

// File: pkg/duc_pins_if.sv
// synchronised pin levels passed from the synchroniser to the counter core
`timescale 1ns/1ps
interface duc_pins_if;
  import duc_pkg::*;
  logic       up_lvl;
  logic       down_lvl;
  logic       master_reset_lvl;
  logic       parallel_load_n_lvl;
  duc_count_t preset_lvl;

  modport src (
    output up_lvl,
    output down_lvl,
    output master_reset_lvl,
    output parallel_load_n_lvl,
    output preset_lvl
  );
  modport dst (
    input up_lvl,
    input down_lvl,
    input master_reset_lvl,
    input parallel_load_n_lvl,
    input preset_lvl
  );
endinterface

// File: src/duc_sync.sv
// two-stage synchroniser for every pin of the counter
`timescale 1ns/1ps
`include "duc_map.svh"
module duc_sync
  import duc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // raw pins
  input  wire logic       up_clock,
  input  wire logic       down_clock,
  input  wire logic       master_reset,
  input  wire logic       parallel_load_n,
  input  wire duc_count_t preset_data,
  // synchronised levels
  duc_pins_if.src         pins
);

  logic [`DUC_SYNC_W-1:0] raw_vec;
  logic [`DUC_SYNC_W-1:0] meta_reg;
  logic [`DUC_SYNC_W-1:0] sync_reg;
  localparam logic [`DUC_SYNC_W-1:0] RST_VEC = `DUC_SYNC_RST;

  assign raw_vec = {preset_data, parallel_load_n, master_reset, down_clock, up_clock};

  // first stage feeds only the second stage
  for (genvar i = 0; i < `DUC_SYNC_W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_reg[i] <= RST_VEC[i];
        sync_reg[i] <= RST_VEC[i];
      end else begin
        meta_reg[i] <= raw_vec[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign pins.up_lvl              = sync_reg[`DUC_PIN_UP];
  assign pins.down_lvl            = sync_reg[`DUC_PIN_DN];
  assign pins.master_reset_lvl    = sync_reg[`DUC_PIN_MR];
  assign pins.parallel_load_n_lvl = sync_reg[`DUC_PIN_LDN];
  assign pins.preset_lvl          = sync_reg[`DUC_PIN_PRE +: `DUC_CNT_W];

endmodule // duc_sync

// File: src/duc_step.sv
// next-up and next-down values for one count step
`timescale 1ns/1ps
`include "duc_map.svh"
module duc_step
  import duc_pkg::*;
#(
  parameter bit DECADE = 1'b0
)(
  // present count
  input  wire duc_count_t value_in,
  // step results
  output duc_count_t      inc_out,
  output duc_count_t      dec_out
);

  duc_count_t top_val;
  assign top_val = duc_max(DECADE);

  // out-of-range decade presets simply climb to 15 and wrap to 0
  always_comb begin
    if (value_in == top_val) begin // [RL15]
      inc_out = `DUC_ZERO;
    end else begin
      inc_out = value_in + `DUC_ONE;
    end
    if (value_in == `DUC_ZERO) begin // [RL15]
      dec_out = top_val;
    end else begin
      dec_out = value_in - `DUC_ONE;
    end
  end

endmodule // duc_step

// File: test/duc_pins_drv.sv
// surrounding logic model driving count clocks, preset, load and reset pins
`timescale 1ns/1ps
module duc_pins_drv
  import duc_pkg::*;
(
  // clock
  input  wire logic clk,
  // pins toward the counter
  output logic       up_clock,
  output logic       down_clock,
  output logic       master_reset,
  output logic       parallel_load_n,
  output duc_count_t preset_data
);
  // two synch stages plus the count register, with margin; also keeps
  // every pin level at least five clk periods long
  localparam int SETTLE = 5;

  initial begin
    up_clock        = 1'b1; // idle count clocks stay high
    down_clock      = 1'b1;
    master_reset    = 1'b0;
    parallel_load_n = 1'b1;
    preset_data     = 4'h0;
  end

  // ************************************************************
  // one pin step: change on a falling edge, then let it settle
  // ************************************************************
  task automatic drive(input logic up, input logic dn, input logic mr,
                       input logic ld_n, input duc_count_t pre);
    @(negedge clk);
    up_clock        <= up;
    down_clock      <= dn;
    master_reset    <= mr;
    parallel_load_n <= ld_n;
    preset_data     <= pre;
    repeat (SETTLE) @(negedge clk);
  endtask
endmodule // duc_pins_drv

// File: test/duc_top_tb.sv
// self-checking bench for the dual clock up/down counter, both variants
`timescale 1ns/1ps
module duc_top_tb;
  import duc_pkg::*;
  localparam int LIMIT = 5000;

  logic       clk;
  logic       rst;
  logic       up_clock;
  logic       down_clock;
  logic       master_reset;
  logic       parallel_load_n;
  duc_count_t preset_data;
  duc_count_t cnt_bin;
  duc_count_t cnt_dec;
  logic       carry_bin_n;
  logic       borrow_bin_n;
  logic       carry_dec_n;
  logic       borrow_dec_n;
  duc_count_t exp_bin;
  duc_count_t exp_dec;
  int         num_errors;
  int         num_checks;
  int         cycles;

  // ************************************************************
  // devices and outside logic
  // ************************************************************
  duc_top #(.DECADE(1'b0)) uut (
    .clk(clk), .rst(rst), .up_clock(up_clock), .down_clock(down_clock),
    .master_reset(master_reset), .parallel_load_n(parallel_load_n),
    .preset_data(preset_data), .count_value(cnt_bin),
    .carry_out_n(carry_bin_n), .borrow_out_n(borrow_bin_n));
  duc_top #(.DECADE(1'b1)) uut_dec (
    .clk(clk), .rst(rst), .up_clock(up_clock), .down_clock(down_clock),
    .master_reset(master_reset), .parallel_load_n(parallel_load_n),
    .preset_data(preset_data), .count_value(cnt_dec),
    .carry_out_n(carry_dec_n), .borrow_out_n(borrow_dec_n));
  duc_pins_drv drv (
    .clk(clk), .up_clock(up_clock), .down_clock(down_clock),
    .master_reset(master_reset), .parallel_load_n(parallel_load_n),
    .preset_data(preset_data));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ************************************************************
  // reference and compare helpers
  // ************************************************************
  function automatic duc_count_t nxt(input duc_count_t v, input bit dec, input bit up);
    duc_count_t top;
    top = dec ? 4'h9 : 4'hF;
    if (up) nxt = (v == top) ? 4'h0 : v + 4'h1;
    else    nxt = (v == 4'h0) ? top : v - 4'h1;
  endfunction

  task automatic chk_cnt(input duc_count_t got, input duc_count_t exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // terminal outputs judged from expected count and present clock levels
  task automatic check_all();
    chk_cnt(cnt_bin, exp_bin);
    chk_cnt(cnt_dec, exp_dec);
    chk_bit(carry_bin_n, !(exp_bin == 4'hF && up_clock == 1'b0));
    chk_bit(carry_dec_n, !(exp_dec == 4'h9 && up_clock == 1'b0));
    chk_bit(borrow_bin_n, !(exp_bin == 4'h0 && down_clock == 1'b0));
    chk_bit(borrow_dec_n, !(exp_dec == 4'h0 && down_clock == 1'b0));
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    exp_bin = 4'h0;
    exp_dec = 4'h0;
    check_all();
    $display("test reset done");
  endtask

  task automatic t_load();
    drv.drive(1'b1, 1'b1, 1'b0, 1'b0, 4'hE);
    exp_bin = 4'hE;
    exp_dec = 4'hE;
    check_all();
    drv.drive(1'b0, 1'b1, 1'b0, 1'b0, 4'h8);
    exp_bin = 4'h8;
    exp_dec = 4'h8;
    check_all();
    drv.drive(1'b0, 1'b1, 1'b0, 1'b1, 4'h8);
    check_all();
    drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h8);
    exp_bin = 4'h9;
    exp_dec = 4'h9;
    check_all();
    $display("test load done");
  endtask

  task automatic t_up();
    for (int i = 0; i < 7; i++) begin
      drv.drive(1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
      check_all();
      drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
      exp_bin = nxt(exp_bin, 1'b0, 1'b1);
      exp_dec = nxt(exp_dec, 1'b1, 1'b1);
      check_all();
    end
    $display("test count up done");
  endtask

  task automatic t_down();
    for (int i = 0; i < 8; i++) begin
      drv.drive(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
      check_all();
      drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
      exp_bin = nxt(exp_bin, 1'b0, 1'b0);
      exp_dec = nxt(exp_dec, 1'b1, 1'b0);
      check_all();
    end
    $display("test count down done");
  endtask

  // counting up with the down clock held low: lowest bit frozen
  task automatic t_both_low();
    drv.drive(1'b1, 1'b0, 1'b0, 1'b0, 4'h2);
    drv.drive(1'b1, 1'b0, 1'b0, 1'b1, 4'h2);
    drv.drive(1'b0, 1'b0, 1'b0, 1'b1, 4'h2);
    drv.drive(1'b1, 1'b0, 1'b0, 1'b1, 4'h2);
    exp_bin = 4'h2;
    exp_dec = 4'h2;
    check_all();
    drv.drive(1'b1, 1'b0, 1'b0, 1'b0, 4'h1);
    drv.drive(1'b1, 1'b0, 1'b0, 1'b1, 4'h1);
    drv.drive(1'b0, 1'b0, 1'b0, 1'b1, 4'h1);
    drv.drive(1'b1, 1'b0, 1'b0, 1'b1, 4'h1);
    exp_bin = 4'h3;
    exp_dec = 4'h3;
    check_all();
    drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h1);
    exp_bin = 4'h2;
    exp_dec = 4'h2;
    check_all();
    $display("test clocks both low done");
  endtask

  task automatic t_master_reset();
    drv.drive(1'b0, 1'b1, 1'b1, 1'b0, 4'h5);
    exp_bin = 4'h0;
    exp_dec = 4'h0;
    check_all();
    drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'h5);
    check_all();
    drv.drive(1'b0, 1'b1, 1'b1, 1'b1, 4'h5);
    check_all();
    drv.drive(1'b0, 1'b1, 1'b0, 1'b1, 4'h5);
    check_all();
    drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    exp_bin = 4'h1;
    exp_dec = 4'h1;
    check_all();
    $display("test master reset done");
  endtask

  // synchronous reset in mid-run; no false edge may follow its release
  task automatic t_sync_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    exp_bin = 4'h0;
    exp_dec = 4'h0;
    repeat (2) @(negedge clk);
    check_all();
    drv.drive(1'b1, 1'b0, 1'b0, 1'b1, 4'h5);
    check_all();
    drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    exp_bin = 4'hF;
    exp_dec = 4'h9;
    check_all();
    $display("test sync reset done");
  endtask

  // ************************************************************
  // closing report and hang guard
  // ************************************************************
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    rst        = 1'b1;
    num_errors = 0;
    num_checks = 0;
    cycles     = 0;
    exp_bin    = 4'h0;
    exp_dec    = 4'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_load();
    t_up();
    t_down();
    t_both_low();
    t_master_reset();
    t_sync_reset();
    end_of_test();
  end
endmodule // duc_top_tb
